// *** rtl/bsc_top.sv ***
// boundary-scan test logic: link sampling, test state machine, cell chain and bypass
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_top #(
   parameter int PIN_COUNT = `BSC_PIN_COUNT,
   parameter int FIFO_DEPTH = `BSC_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   input wire logic [PIN_COUNT-1:0] core_out,
   input wire logic [PIN_COUNT-1:0] core_oe,
   input wire logic [PIN_COUNT-1:0] pin_in,
   output logic [PIN_COUNT-1:0] pin_out,
   output logic [PIN_COUNT-1:0] pin_oe_n
);
   localparam int CHAIN_LEN = PIN_COUNT * `BSC_CELL_BITS;
   localparam int IRW = `BSC_IR_WIDTH;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   ////////////////////////////////////////////////////////////////////////
   // test state machine step on a rising tck

   function automatic bsc_pkg::bsc_tap_type tap_step(input bsc_pkg::bsc_tap_type s, input logic m);
      case (s)
         bsc_pkg::TLR:    tap_step = m ? bsc_pkg::TLR : bsc_pkg::IDLE;
         bsc_pkg::IDLE:   tap_step = m ? bsc_pkg::SEL_DR : bsc_pkg::IDLE;
         bsc_pkg::SEL_DR: tap_step = m ? bsc_pkg::SEL_IR : bsc_pkg::CAP_DR;
         bsc_pkg::CAP_DR: tap_step = m ? bsc_pkg::EX1_DR : bsc_pkg::SHF_DR;
         bsc_pkg::SHF_DR: tap_step = m ? bsc_pkg::EX1_DR : bsc_pkg::SHF_DR;
         bsc_pkg::EX1_DR: tap_step = m ? bsc_pkg::UPD_DR : bsc_pkg::PAU_DR;
         bsc_pkg::PAU_DR: tap_step = m ? bsc_pkg::EX2_DR : bsc_pkg::PAU_DR;
         bsc_pkg::EX2_DR: tap_step = m ? bsc_pkg::UPD_DR : bsc_pkg::SHF_DR;
         bsc_pkg::UPD_DR: tap_step = m ? bsc_pkg::SEL_DR : bsc_pkg::IDLE;
         bsc_pkg::SEL_IR: tap_step = m ? bsc_pkg::TLR : bsc_pkg::CAP_IR;
         bsc_pkg::CAP_IR: tap_step = m ? bsc_pkg::EX1_IR : bsc_pkg::SHF_IR;
         bsc_pkg::SHF_IR: tap_step = m ? bsc_pkg::EX1_IR : bsc_pkg::SHF_IR;
         bsc_pkg::EX1_IR: tap_step = m ? bsc_pkg::UPD_IR : bsc_pkg::PAU_IR;
         bsc_pkg::PAU_IR: tap_step = m ? bsc_pkg::EX2_IR : bsc_pkg::PAU_IR;
         bsc_pkg::EX2_IR: tap_step = m ? bsc_pkg::UPD_IR : bsc_pkg::SHF_IR;
         bsc_pkg::UPD_IR: tap_step = m ? bsc_pkg::SEL_DR : bsc_pkg::IDLE;
         default:         tap_step = bsc_pkg::TLR;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // link and pin synchronisers

   logic [2:0] link_s1;
   logic [2:0] link_s2;
   logic [PIN_COUNT-1:0] pin_s1;
   logic [PIN_COUNT-1:0] pin_s2;

   // two flops on every pin from outside the clock domain
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         link_s1 <= '0;
         link_s2 <= '0;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end
      else
      begin
         link_s1 <= {tck, tms, tdi};
         link_s2 <= link_s1;
         pin_s1 <= pin_in;
         pin_s2 <= pin_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tck edge detection into the event buffer

   bsc_stream_if #(.W(`BSC_EV_WIDTH)) ev_in ();
   bsc_stream_if #(.W(`BSC_EV_WIDTH)) ev_out ();

   logic tck_prev;
   wire tck_now = link_s2[2];
   wire tck_edge = tck_now != tck_prev;

   // every tck edge becomes one event word
   assign ev_in.valid = tck_edge;
   assign ev_in.data = {tck_now, link_s2[1], link_s2[0]};

   // edge is held and retried while the buffer is full
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         tck_prev <= 1'b0;
      else if (ev_in.ready)
         tck_prev <= tck_now;
   end

   bsc_fifo #(
      .W(`BSC_EV_WIDTH),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .srst(srst),
      .push(ev_in),
      .pop(ev_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // event taking, one event every other cycle at most

   logic busy;
   assign ev_out.ready = ~busy;

   wire ev_take = ev_out.valid & ev_out.ready;
   wire ev_rise = ev_out.data[`BSC_EV_RISE];
   wire ev_tms = ev_out.data[`BSC_EV_TMS];
   wire ev_tdi = ev_out.data[`BSC_EV_TDI];
   wire rise_take = ev_take & ev_rise;
   wire fall_take = ev_take & ~ev_rise;

   // one settle cycle after each event
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         busy <= 1'b0;
      else
         busy <= ev_take;
   end

   ////////////////////////////////////////////////////////////////////////
   // test state machine

   bsc_pkg::bsc_tap_type tap;
   bsc_pkg::bsc_tap_type next_tap;

   // state moves only on rising tck events
   assign next_tap = rise_take ? tap_step(tap, ev_tms) : tap;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         tap <= bsc_pkg::TLR;
      else
         tap <= next_tap;
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction register and mode decode

   logic [IRW-1:0] ir_shift;
   logic [IRW-1:0] ir_active;

   // shift stage, low bit leaves first
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         ir_shift <= `BSC_IR_BYPASS;
      else if (rise_take && tap == bsc_pkg::CAP_IR)
         ir_shift <= `BSC_IR_CAPTURE;
      else if (rise_take && tap == bsc_pkg::SHF_IR)
         ir_shift <= {ev_tdi, ir_shift[IRW-1:1]};
   end

   // active instruction loads on the falling edge in update-ir
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         ir_active <= `BSC_IR_BYPASS;
      else if (tap == bsc_pkg::TLR)
         ir_active <= `BSC_IR_BYPASS;
      else if (fall_take && tap == bsc_pkg::UPD_IR)
         ir_active <= ir_shift;
   end

   // cell mode and data register selection from the active instruction
   wire extest_mode = ir_active == `BSC_IR_EXTEST;
   wire sample_mode = ir_active == `BSC_IR_SAMPLE;
   wire boundary_sel = extest_mode | sample_mode;
   wire bypass_sel = ~boundary_sel;

   ////////////////////////////////////////////////////////////////////////
   // internal cell strobes

   // strobes are built here from tap state, never from pins
   wire shift_en = rise_take & (tap == bsc_pkg::SHF_DR) & boundary_sel;
   wire capture_en = rise_take & (tap == bsc_pkg::CAP_DR) & boundary_sel;
   wire update_en = fall_take & (tap == bsc_pkg::UPD_DR) & boundary_sel;

   ////////////////////////////////////////////////////////////////////////
   // boundary cell chain

   logic [PIN_COUNT:0] serial_link;
   logic [CHAIN_LEN-1:0] chain;
   logic [PIN_COUNT-1:0] upd_out;
   logic [PIN_COUNT-1:0] upd_oe;

   assign serial_link[0] = ev_tdi;

   // cells in order from tdi to tdo
   for (genvar i = 0; i < PIN_COUNT; i++)
   begin : g_cell
      wire [`BSC_CELL_BITS-1:0] cell_cap = {pin_out[i], ~pin_oe_n[i], pin_s2[i]};
      wire [1:0] cell_upd;

      bsc_cell u_cell (
         .clk_sys(clk_sys),
         .srst(srst),
         .shift_en(shift_en),
         .capture_en(capture_en),
         .update_en(update_en),
         .cell_serial_input(serial_link[i]),
         .cap_in(cell_cap),
         .cell_serial_output(serial_link[i+1]),
         .shift_bits(chain[i*`BSC_CELL_BITS +: `BSC_CELL_BITS]),
         .upd_bits(cell_upd)
      );

      assign upd_oe[i] = cell_upd[1];
      assign upd_out[i] = cell_upd[0];
   end

   ////////////////////////////////////////////////////////////////////////
   // bypass register

   logic byp;

   // one bit path, cleared in capture, loaded from tdi in shift
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         byp <= 1'b0;
      else if (rise_take && tap == bsc_pkg::CAP_DR && bypass_sel)
         byp <= 1'b0;
      else if (rise_take && tap == bsc_pkg::SHF_DR && bypass_sel)
         byp <= ev_tdi;
   end

   ////////////////////////////////////////////////////////////////////////
   // test data output, changed on falling tck events

   wire dr_tail = bypass_sel ? byp : serial_link[PIN_COUNT];
   wire shifting = (tap == bsc_pkg::SHF_DR) | (tap == bsc_pkg::SHF_IR);
   wire next_tdo = (tap == bsc_pkg::SHF_IR) ? ir_shift[0] : dr_tail;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end
      else if (fall_take)
      begin
         if (shifting)
            tdo <= next_tdo;
         tdo_oe_n <= ~shifting;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drive selection

   // extest hands the pins to the update registers, otherwise the core
   wire [PIN_COUNT-1:0] next_pin_out = extest_mode ? upd_out : core_out;
   wire [PIN_COUNT-1:0] next_pin_oe = extest_mode ? upd_oe : core_oe;

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         pin_out <= '0;
         pin_oe_n <= '1;
      end
      else
      begin
         pin_out <= next_pin_out;
         pin_oe_n <= ~next_pin_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_byp_rise;
      rise_take && tap == bsc_pkg::SHF_DR && bypass_sel;
   endsequence

   sequence s_shift_fall;
      fall_take && tap == bsc_pkg::SHF_DR;
   endsequence

   property p_byp_sample;
      s_byp_rise |=> byp == $past(ev_tdi);
   endproperty
   a_byp_sample: assert property (p_byp_sample) else $error("bypass bit not taken from tdi");

   property p_byp_tdo;
      s_shift_fall and bypass_sel |=> tdo == $past(byp) && !tdo_oe_n;
   endproperty
   a_byp_tdo: assert property (p_byp_tdo) else $error("tdo does not show bypass bit");

   property p_chain_tdo;
      s_shift_fall and boundary_sel |=> tdo == $past(chain[CHAIN_LEN-1]);
   endproperty
   a_chain_tdo: assert property (p_chain_tdo) else $error("tdo does not show last chain bit");

   property p_chain_shift;
      shift_en |=> chain == {$past(chain[CHAIN_LEN-2:0]), $past(ev_tdi)};
   endproperty
   a_chain_shift: assert property (p_chain_shift) else $error("chain did not move one place");

   property p_extest_pins;
      extest_mode |=> pin_out == $past(upd_out) && pin_oe_n == ~$past(upd_oe);
   endproperty
   a_extest_pins: assert property (p_extest_pins) else $error("extest pins not from update data");

   property p_sample_pins;
      !extest_mode |=> pin_out == $past(core_out) && pin_oe_n == ~$past(core_oe);
   endproperty
   a_sample_pins: assert property (p_sample_pins) else $error("core lost the pins outside extest");

   property p_ir_update;
      fall_take && tap == bsc_pkg::UPD_IR |=> ir_active == $past(ir_shift);
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("instruction not loaded in update");

   property p_tap_exit;
      rise_take && tap == bsc_pkg::SHF_DR && ev_tms |=> tap == bsc_pkg::EX1_DR ##1 tap == bsc_pkg::EX1_DR;
   endproperty
   a_tap_exit: assert property (p_tap_exit) else $error("shift-dr did not leave to exit1");

   // first cell must hold what stood on its pin at the capture strobe
   property p_capture_pins;
      capture_en |=> chain[`BSC_CELL_BITS-1:0] == {$past(pin_out[0]), ~$past(pin_oe_n[0]), $past(pin_s2[0])};
   endproperty
   a_capture_pins: assert property (p_capture_pins) else $error("capture did not latch pin values");
endmodule

// *** common/bsc_map.svh ***
// constants, codes and bit positions of the boundary-scan test logic
//
// Notes on behaviour
// - each cell captures the synchronised pin input so it can be shifted out
// - update registers drive pin value and enable when a cell overrides the core
// - shift, capture and update strobes come from the internal test state machine only
// - the pin override mode comes from decoding the active instruction register
// - serial data runs cell to cell from tdi through the chain to tdo
// - under extest the pin value and enable take update register data
// - entering extest at once drives values already held in the update registers
// - capture phase latches pin values, shift phase moves them out on tdo
// - update phase copies the shifted data into the update registers
// - data shifted in on tdi leaves tdo only after every chain cell
// - an all-ones instruction selects the one-bit bypass register for the data path
// - bypass samples tdi on rising tck, shows it on tdo at the following fall
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH

// instruction register width and codes
`define BSC_IR_WIDTH 4
`define BSC_IR_EXTEST 4'h0
`define BSC_IR_SAMPLE 4'h5
`define BSC_IR_BYPASS 4'hF
`define BSC_IR_CAPTURE 4'h1

// structure defaults
`define BSC_PIN_COUNT 8
`define BSC_FIFO_DEPTH 8

// link event word: edge kind, mode select, serial data
`define BSC_EV_WIDTH 3
`define BSC_EV_RISE 2
`define BSC_EV_TMS 1
`define BSC_EV_TDI 0

// shift bits inside one pin cell, tdi side first
`define BSC_CELL_BITS 3
`define BSC_CELL_IN 0
`define BSC_CELL_OE 1
`define BSC_CELL_OUT 2

`endif

// *** common/bsc_pkg.sv ***
// types shared by the boundary-scan test logic
package bsc_pkg;

   // test access port controller states, one-hot
   typedef enum logic [15:0] {
      TLR    = 16'h0001,
      IDLE   = 16'h0002,
      SEL_DR = 16'h0004,
      CAP_DR = 16'h0008,
      SHF_DR = 16'h0010,
      EX1_DR = 16'h0020,
      PAU_DR = 16'h0040,
      EX2_DR = 16'h0080,
      UPD_DR = 16'h0100,
      SEL_IR = 16'h0200,
      CAP_IR = 16'h0400,
      SHF_IR = 16'h0800,
      EX1_IR = 16'h1000,
      PAU_IR = 16'h2000,
      EX2_IR = 16'h4000,
      UPD_IR = 16'h8000
   } bsc_tap_type;

endpackage

// *** common/bsc_stream_if.sv ***
// valid and ready stream carrier between the scan logic modules
`timescale 1ns/1ps
interface bsc_stream_if #(
   parameter int W = 3
);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface

// *** rtl/bsc_fifo.sv ***
// first-in first-out buffer of link events ahead of the test state machine
`timescale 1ns/1ps
module bsc_fifo #(
   parameter int W = 3,
   parameter int D = 8
) (
   input wire logic clk_sys,
   input wire logic srst,
   bsc_stream_if.sink push,
   bsc_stream_if.source pop
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam logic [AW:0] FULL_COUNT = (AW + 1)'(D);
   localparam logic [AW-1:0] LAST_SLOT = AW'(D - 1);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;

   // handshakes and honest flags
   wire do_push = push.valid & push.ready;
   wire do_pop = pop.valid & pop.ready;
   assign push.ready = count != FULL_COUNT;
   assign pop.valid = count != '0;
   assign pop.data = mem[rd_ptr];

   // next pointers wrap for any depth
   wire [AW-1:0] next_wr_ptr = (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
   wire [AW-1:0] next_rd_ptr = (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;

   // storage write
   always_ff @(posedge clk_sys)
   begin
      if (do_push)
         mem[wr_ptr] <= push.data;
   end

   // pointers and fill level
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr <= next_wr_ptr;
         if (do_pop)
            rd_ptr <= next_rd_ptr;
         if (do_push && !do_pop)
            count <= count + 1'b1;
         else if (do_pop && !do_push)
            count <= count - 1'b1;
      end
   end
endmodule

// *** rtl/bsc_cell.sv ***
// one user pin boundary-scan cell: capture, shift and update stages
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_cell (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic shift_en,
   input wire logic capture_en,
   input wire logic update_en,
   input wire logic cell_serial_input,
   input wire logic [`BSC_CELL_BITS-1:0] cap_in,
   output logic cell_serial_output,
   output logic [`BSC_CELL_BITS-1:0] shift_bits,
   output logic [1:0] upd_bits
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   // capture and shift stage
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         shift_bits <= '0;
      else if (capture_en)
         shift_bits <= cap_in;
      else if (shift_en)
         shift_bits <= {shift_bits[`BSC_CELL_BITS-2:0], cell_serial_input};
   end

   // update stage: bit 1 is the enable, bit 0 the value
   always_ff @(posedge clk_sys)
   begin
      if (srst)
         upd_bits <= '0;
      else if (update_en)
         upd_bits <= {shift_bits[`BSC_CELL_OE], shift_bits[`BSC_CELL_OUT]};
   end

   assign cell_serial_output = shift_bits[`BSC_CELL_BITS-1];

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_cell_capture;
      capture_en |=> shift_bits == $past(cap_in) ##1 (shift_en || capture_en || shift_bits == $past(shift_bits));
   endproperty
   a_cell_capture: assert property (p_cell_capture) else $error("cell capture lost pin value");

   property p_cell_update;
      update_en |=> upd_bits == {$past(shift_bits[`BSC_CELL_OE]), $past(shift_bits[`BSC_CELL_OUT])};
   endproperty
   a_cell_update: assert property (p_cell_update) else $error("cell update did not copy shift bits");
endmodule

// *** verification/bsc_ctrl_model.sv ***
// board test controller model driving the four-wire test port
`timescale 1ns/1ps
module bsc_ctrl_model (
   input wire logic clk_sys,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   output logic obs_valid,
   output logic [1:0] obs
);
   // test clock parked low, outside any frame
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      obs_valid = 1'b0;
      obs = 2'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wait whole system cycles, then step off the edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // one 80 ns test clock pulse, 8 cycles a half; tdo looked at late in the low half
   task automatic pulse(input logic m, input logic d, input bit look);
      tms = m;
      tdi = d;
      step(2);
      obs_valid = 1'b0;
      tck = 1'b1;
      step(8);
      tck = 1'b0;
      step(6);
      if (look)
      begin
         obs = {tdo_oe_n, tdo};
         obs_valid = 1'b1;
      end
   endtask

   // force test-logic-reset, then settle in run-test-idle
   task automatic to_idle();
      repeat (5) pulse(1'b1, ~tdi, 1'b0);
      pulse(1'b0, ~tdi, 1'b0);
   endtask

   // idle, one data or instruction scan of n bits, update, idle again
   task automatic scan(input bit ir, input int n, input logic [47:0] v, input bit lsb);
      pulse(1'b1, tdi, 1'b0);
      if (ir)
         pulse(1'b1, tdi, 1'b0);
      pulse(1'b0, tdi, 1'b0);
      pulse(1'b0, tdi, 1'b1);
      for (int i = 0; i < n; i++)
         pulse(i == n - 1, lsb ? v[i] : v[n - 1 - i], i < n - 1);
      // released data line shows the inverse of the last bit
      pulse(1'b1, ~tdi, 1'b0);
      pulse(1'b0, ~tdi, 1'b0);
   endtask
endmodule

// *** verification/test_boundary_scan_cell_bypass.sv ***
// self-checking bench for the boundary-scan test logic and its event buffer
`timescale 1ns/1ps
module test_boundary_scan_cell_bypass;
   localparam int N = 8;
   localparam int CB = 3 * N;
   logic clk_sys, srst, tck, tms, tdi, tdo, tdo_oe_n, obs_valid;
   logic [1:0] obs;
   logic [N-1:0] core_out, core_oe, pin_in, pin_out, pin_oe_n;
   logic [1:0] exp_q[$];
   logic [CB-1:0] upd, cap, pat;
   int n_fail = 0;
   int compares = 0;
   int seed = 32'h2FF7;

   bsc_top #(.PIN_COUNT(N), .FIFO_DEPTH(8)) u_bsc_top (
      .clk_sys(clk_sys), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
   );

   bsc_ctrl_model u_bsc_ctrl_model (
      .clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .obs_valid(obs_valid), .obs(obs)
   );

   // 200 MHz system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // verdict and end of run
   task automatic finish_test();
      check("tdo notes left over", 48'h0, exp_q.size());
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // note the tdo bits of one scan, enable low while shifting
   task automatic expect_scan(input int n, input logic [47:0] v, input bit lsb);
      for (int i = 0; i < n; i++)
         exp_q.push_back({1'b0, lsb ? v[i] : v[n - 1 - i]});
   endtask

   // capture word of the chain, pin 0 nearest tdi
   function automatic logic [CB-1:0] cap_of(input logic [N-1:0] o, input logic [N-1:0] e, input logic [N-1:0] i);
      for (int p = 0; p < N; p++)
         cap_of[3*p +: 3] = {o[p], e[p], i[p]};
   endfunction

   // pin enables and values driven from an update word
   function automatic logic [2*N-1:0] pins_of(input logic [CB-1:0] u);
      for (int p = 0; p < N; p++)
      begin
         pins_of[p] = u[3*p+2];
         pins_of[N+p] = ~u[3*p+1];
      end
   endfunction

   // watcher: oldest note against each tdo observation
   always @(posedge obs_valid)
   begin
      if (exp_q.size() == 0)
         check("tdo observation without note", 48'h0, 48'h1);
      else
         check("tdo enable and data", {46'h0, exp_q.pop_front()}, {46'h0, obs});
   end

   // bounded run time
   initial
   begin
      for (int w = 0; w < 50000; w++)
         @(posedge clk_sys);
      n_fail++;
      finish_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      srst = 1'b1;
      core_out = N'($random(seed));
      core_oe = N'($random(seed));
      pin_in = N'($random(seed));
      u_bsc_ctrl_model.step(2);
      check("tdo_oe_n in reset", 48'h1, tdo_oe_n);
      check("pin_oe_n in reset", {N{1'b1}}, pin_oe_n);
      srst = 1'b0;
      u_bsc_ctrl_model.step(4);
      check("pins follow core", {~core_oe, core_out}, {pin_oe_n, pin_out});
      u_bsc_ctrl_model.to_idle();
      // all-ones and an unused code both give a one-bit data path
      for (int k = 0; k < 2; k++)
      begin
         expect_scan(4, 48'h1, 1);
         u_bsc_ctrl_model.scan(1, 4, k ? 48'h3 : 48'hF, 1);
         upd = CB'($random(seed));
         expect_scan(16, {33'h0, upd[15:1]}, 0);
         u_bsc_ctrl_model.scan(0, 16, {32'h0, upd[15:0]}, 0);
      end
      // sample and preload: pins stay with the core
      expect_scan(4, 48'h1, 1);
      u_bsc_ctrl_model.scan(1, 4, 48'h5, 1);
      core_out = N'($random(seed));
      core_oe = N'($random(seed));
      pin_in = N'($random(seed));
      u_bsc_ctrl_model.step(4);
      check("pins with core in sample", {~core_oe, core_out}, {pin_oe_n, pin_out});
      upd = CB'($random(seed));
      expect_scan(CB, {24'h0, cap_of(core_out, core_oe, pin_in)}, 0);
      u_bsc_ctrl_model.scan(0, CB, {24'h0, upd}, 0);
      check("pins with core after preload", {~core_oe, core_out}, {pin_oe_n, pin_out});
      // external test: preloaded values reach the pins at once
      expect_scan(4, 48'h1, 1);
      u_bsc_ctrl_model.scan(1, 4, 48'h0, 1);
      check("pins from update registers", pins_of(upd), {pin_oe_n, pin_out});
      pin_in = N'($random(seed));
      u_bsc_ctrl_model.step(4);
      cap = (upd & 24'hDB6DB6) | cap_of(8'h00, 8'h00, pin_in);
      pat = CB'($random(seed));
      expect_scan(48, {cap, pat}, 0);
      upd = CB'($random(seed));
      u_bsc_ctrl_model.scan(0, 48, {pat, upd}, 0);
      core_out = ~core_out;
      u_bsc_ctrl_model.step(2);
      check("pins take new update data", pins_of(upd), {pin_oe_n, pin_out});
      // second reset in mid-run: bypass again, pins back with the core
      srst = 1'b1;
      core_oe = N'($random(seed));
      pin_in = N'($random(seed));
      u_bsc_ctrl_model.step(2);
      check("tdo in reset", 48'h0, tdo);
      check("tdo_oe_n in second reset", 48'h1, tdo_oe_n);
      check("pin_out in reset", 48'h0, pin_out);
      check("pin_oe_n in second reset", {N{1'b1}}, pin_oe_n);
      srst = 1'b0;
      u_bsc_ctrl_model.step(4);
      check("pins follow core after reset", {~core_oe, core_out}, {pin_oe_n, pin_out});
      u_bsc_ctrl_model.to_idle();
      upd = CB'($random(seed));
      expect_scan(8, {41'h0, upd[7:1]}, 0);
      u_bsc_ctrl_model.scan(0, 8, {40'h0, upd[7:0]}, 0);
      finish_test();
   end
endmodule
